// ==== hdl/adc_chain.sv ====
// Top of the daisy-chain readout: start detection, mode capture,
// conversion timing and power-down on mclk, shifting on the shift clock.
// Assumes sample_code is the settled code of the analog front end on mclk.
`timescale 1ns/1ns
`include "adc_params.svh"
module adc_chain (
   input  wire logic        mclk,
   input  wire logic        nrst,
   input  wire logic        sclk,
   input  wire logic        conversion_start,
   input  wire logic        chain_data_in,
   input  wire logic [15:0] sample_code,
   output logic             serial_result_out,
   output logic             serial_result_out_oe,
   output logic             sample_take,
   output logic             converting,
   output logic             power_down,
   output logic             chain_mode,
   output logic             busy_mode
);
   adc_link_if lk ();

   // Three-stage synchronisers for start, chain input and shift-clock level
   logic [2:0] pin_in;
   logic [2:0] s1_reg, s1_next;
   logic [2:0] s2_reg, s2_next;
   logic [2:0] s3_reg, s3_next;
   logic [2:0] st_reg, st_next;

   assign pin_in = {sclk, chain_data_in, conversion_start};

   always_comb begin
      s1_next = pin_in;
      s2_next = s1_reg;
      s3_next = s2_reg;
      st_next = st_reg;
      for (int i = 0; i < `ADC_SYNC_DEPTH; i++) begin
         if (s2_reg[i] == s3_reg[i]) begin
            st_next[i] = s3_reg[i];
         end
      end
   end

   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         s1_reg <= 3'h0;
         s2_reg <= 3'h0;
         s3_reg <= 3'h0;
         st_reg <= 3'h0;
      end else begin
         s1_reg <= s1_next;
         s2_reg <= s2_next;
         s3_reg <= s3_next;
         st_reg <= st_next;
      end
   end

   // History of the settled chain input, so a level that rises with start
   // is judged by its value from before the edge
   logic [1:0] din_hist_reg, din_hist_next;
   logic       start_prev_reg, start_prev_next;
   logic       start_rise;
   logic       start_fall;

   always_comb begin
      din_hist_next   = {din_hist_reg[0], st_reg[1]};
      start_prev_next = st_reg[0];
      start_rise      = st_reg[0] && !start_prev_reg;
      start_fall      = !st_reg[0] && start_prev_reg;
   end

   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         din_hist_reg   <= 2'h3;
         start_prev_reg <= 1'h0;
      end else begin
         din_hist_reg   <= din_hist_next;
         start_prev_reg <= start_prev_next;
      end
   end

   // Conversion sequencer
   adc_pkg::adc_state_type state_reg, state_next;
   logic [`ADC_CONV_W-1:0] conv_cnt_reg,   conv_cnt_next;
   adc_pkg::adc_word_type  code_reg,       code_next;
   adc_pkg::adc_word_type  result_reg,     result_next;
   logic                   chain_reg,      chain_next;
   logic                   busy_reg,       busy_next;
   logic                   first_bit_reg,  first_bit_next;
   logic                   clr_n_reg,      clr_n_next;
   logic                   pd_reg,         pd_next;
   logic                   take_reg,       take_next;

   always_comb begin
      state_next     = state_reg;
      conv_cnt_next  = conv_cnt_reg;
      code_next      = code_reg;
      result_next    = result_reg;
      chain_next     = chain_reg;
      busy_next      = busy_reg;
      first_bit_next = first_bit_reg;
      clr_n_next     = clr_n_reg;
      pd_next        = pd_reg;
      take_next      = 1'h0;
      case (state_reg)
         adc_pkg::ADC_ST_IDLE, adc_pkg::ADC_ST_ACQUIRE: begin
            if (start_rise) begin
               // Start edge samples the input and wakes the converter;
               state_next     = adc_pkg::ADC_ST_CONVERT;
               take_next      = 1'h1;
               code_next      = sample_code;
               conv_cnt_next  = `ADC_CONV_W'(`ADC_CONV_CYC - 1);
               chain_next     = !din_hist_reg[1];
               busy_next      = st_reg[2];
               first_bit_next = 1'h0;
               clr_n_next     = 1'h0;
               pd_next        = 1'h0;
            end else if (state_reg == adc_pkg::ADC_ST_ACQUIRE) begin
               clr_n_next = 1'h1;
               if (start_fall) begin
                  // Readout is over once start drops
                  state_next = adc_pkg::ADC_ST_IDLE;
               end
            end
         end
         adc_pkg::ADC_ST_CONVERT: begin
            // Runs on mclk only; the shift clock has no say here
            if (conv_cnt_reg == 8'h00) begin
               state_next  = adc_pkg::ADC_ST_ACQUIRE;
               result_next = code_reg;
               // Busy variant shows the busy level first, else the MSB;
               first_bit_next = busy_reg ? `ADC_BUSY_BIT : code_reg[`ADC_WORD_W-1];
               pd_next        = 1'h1;
            end else begin
               conv_cnt_next = conv_cnt_reg - 8'h01;
            end
         end
         default: begin
            state_next = adc_pkg::ADC_ST_IDLE;
            clr_n_next = 1'h0;
         end
      endcase
   end

   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         state_reg     <= adc_pkg::ADC_ST_IDLE;
         conv_cnt_reg  <= 8'h00;
         code_reg      <= `ADC_CODE_RESET;
         result_reg    <= `ADC_CODE_RESET;
         chain_reg     <= 1'h0;
         busy_reg      <= 1'h0;
         first_bit_reg <= 1'h0;
         clr_n_reg     <= 1'h0;
         pd_reg        <= 1'h1;
         take_reg      <= 1'h0;
      end else begin
         state_reg     <= state_next;
         conv_cnt_reg  <= conv_cnt_next;
         code_reg      <= code_next;
         result_reg    <= result_next;
         chain_reg     <= chain_next;
         busy_reg      <= busy_next;
         first_bit_reg <= first_bit_next;
         clr_n_reg     <= clr_n_next;
         pd_reg        <= pd_next;
         take_reg      <= take_next;
      end
   end

   // Result and mode only change while the shifter is held cleared
   assign lk.result     = result_reg;
   assign lk.busy_mode  = busy_reg;
   assign lk.link_clr_n = nrst & clr_n_reg;

   adc_shifter u_shifter (
      .sclk          (sclk),
      .chain_data_in (chain_data_in),
      .lk            (lk.shift)
   );

   // Before the first fall the mclk side supplies the opening bit
   assign serial_result_out    = lk.started ? lk.sdo_bit : first_bit_reg;
   assign serial_result_out_oe = chain_reg;
   assign sample_take          = take_reg;
   assign converting           = (state_reg == adc_pkg::ADC_ST_CONVERT);
   assign power_down           = pd_reg;
   assign chain_mode           = chain_reg;
   assign busy_mode            = busy_reg;
endmodule

// ==== hdl/adc_link_if.sv ====
// Signals between the mclk-domain control and the shift-clock shifter.
// Result and mode stay still whenever the shifter may see an edge.
`timescale 1ns/1ns
interface adc_link_if;
   adc_pkg::adc_word_type result;
   logic                  busy_mode;
   logic                  link_clr_n;
   logic                  started;
   logic                  sdo_bit;

   modport ctrl  (output result, output busy_mode, output link_clr_n,
                  input started, input sdo_bit);
   modport shift (input result, input busy_mode, input link_clr_n,
                  output started, output sdo_bit);
endinterface

// ==== hdl/adc_params.svh ====
// Constants of the daisy-chain readout block: timing counts, widths and codes.
// Assumes a 50 MHz mclk; included by bare name from the design files.
//
// Summary of operation
// - Chain input low at start selects chain.
// - Serial output driven low during conversion start, in chain mode only.
// - Shift clock low at start: no busy bit.
// - Conversion completes whatever the shift clock does.
// - No busy: MSB at end, shift on falls.
// - Chain input captured on every falling edge; falls during conversion are ignored while the shifter is held cleared.
// - First device output low after sixteenth fall.
// - Predecessor data forwarded MSB first, no gap.
// - Chain still chosen when input rises with start.
// - Start rise samples input and begins conversion.
// - Shift clock high at start: busy bit.
// - Busy bit first, MSB after first fall.
// - First device output high after seventeenth fall.
// - Power down after conversion, up at start.
// - Previous result readable during acquisition.
// - Conversion lasts fixed internal-clock time.
// - Result is sixteen-bit straight binary.
`ifndef ADC_PARAMS_SVH
`define ADC_PARAMS_SVH

`define ADC_WORD_W         16
`define ADC_CNT_W          5
`define ADC_CONV_W         8
`define ADC_MCLK_PERIOD_NS 20
`define ADC_T_CONV_NS      1400
`define ADC_CONV_CYC       ((`ADC_T_CONV_NS + `ADC_MCLK_PERIOD_NS - 1) / `ADC_MCLK_PERIOD_NS)
`define ADC_OWN_LEN        5'h10
`define ADC_OWN_LEN_BUSY   5'h11
`define ADC_MSB_POS        5'h0F
`define ADC_BUSY_BIT       1'h0
`define ADC_CODE_RESET     16'h0000
`define ADC_SYNC_DEPTH     3

`endif

// ==== hdl/adc_pkg.sv ====
// Types shared by the readout block.
// Assumes the constants header is compiled alongside.
package adc_pkg;

   typedef enum logic [1:0] {
      ADC_ST_IDLE    = 2'b00,
      ADC_ST_CONVERT = 2'b01,
      ADC_ST_ACQUIRE = 2'b10
   } adc_state_type;

   typedef logic [15:0] adc_word_type;

endpackage

// ==== hdl/adc_shifter.sv ====
// Shift-clock domain: counts falling edges, shifts the chain input through,
// and chooses between the own word and the forwarded predecessor data.
// Assumes link_clr_n is held low for the whole conversion.
`timescale 1ns/1ns
`include "adc_params.svh"
module adc_shifter (
   input  wire logic  sclk,
   input  wire logic  chain_data_in,
   adc_link_if.shift  lk
);
   logic [`ADC_CNT_W-1:0]  cnt_reg,     cnt_next;
   logic [`ADC_WORD_W-1:0] sr_reg,      sr_next;
   logic                   sdo_reg,     sdo_next;
   logic                   started_reg, started_next;
   logic [`ADC_CNT_W-1:0]  k;
   logic [`ADC_CNT_W-1:0]  idx;
   logic [`ADC_CNT_W-1:0]  own_len;
   logic [`ADC_CNT_W-1:0]  pos;

   always_comb begin
      own_len  = lk.busy_mode ? `ADC_OWN_LEN_BUSY : `ADC_OWN_LEN;
      k        = cnt_reg + 5'h01;
      cnt_next = (cnt_reg == own_len) ? cnt_reg : k;
      // Capture on the fall, before the predecessor moves on
      sr_next  = {sr_reg[`ADC_WORD_W-2:0], chain_data_in};
      idx      = lk.busy_mode ? k - 5'h01 : k;
      pos      = `ADC_MSB_POS - idx;
      sdo_next = sr_next[`ADC_WORD_W-1];
      if (k < own_len) begin
         sdo_next = lk.result[pos[3:0]];
      end
      // After the own word the delay line holds the predecessor MSB first;
      started_next = 1'h1;
   end

   always_ff @(negedge sclk or negedge lk.link_clr_n) begin
      if (!lk.link_clr_n) begin
         cnt_reg     <= 5'h00;
         sr_reg      <= 16'h0000;
         sdo_reg     <= 1'h0;
         started_reg <= 1'h0;
      end else begin
         cnt_reg     <= cnt_next;
         sr_reg      <= sr_next;
         sdo_reg     <= sdo_next;
         started_reg <= started_next;
      end
   end

   assign lk.started = started_reg;
   assign lk.sdo_bit = sdo_reg;
endmodule

// ==== tb/adc_chain_peer.sv ====
// Predecessor in the chain: own word, grounded, tied to start, or high.
// Assumes ready rises at conversion end and falls before the next start.
`timescale 1ns/1ns
module adc_chain_peer (
   input wire logic        sclk,
   input wire logic        conversion_start,
   input wire logic        ready,
   input wire logic [1:0]  wiring,
   input wire logic [15:0] word,
   output logic            chain_data_in
);
   logic [15:0] shift_reg;

   // Word held while converting, then shifted out MSB first on falls
   always @(negedge sclk or negedge ready) begin
      if (!ready) shift_reg <= word;
      else shift_reg <= {shift_reg[14:0], 1'b0};
   end

   // Own-word wiring is low while converting, keeping the neighbour in chain mode
   always_comb begin
      case (wiring)
         2'h1:    chain_data_in = 1'b0;
         2'h2:    chain_data_in = conversion_start;
         2'h3:    chain_data_in = 1'b1;
         default: chain_data_in = ready & shift_reg[15];
      endcase
   end
endmodule

// ==== tb/adc_chain_sva.sv ====
// Port checker of the daisy-chain readout top.
// Assumes one mclk domain with async active-low nrst.
`timescale 1ns/1ns
module adc_chain_sva (
   input wire logic mclk,
   input wire logic nrst,
   input wire logic serial_result_out,
   input wire logic serial_result_out_oe,
   input wire logic sample_take,
   input wire logic converting,
   input wire logic power_down,
   input wire logic chain_mode,
   input wire logic busy_mode
);
   default clocking cb @(posedge mclk); endclocking
   default disable iff (!nrst);

   chk_take_single: assert property (sample_take |=> !sample_take)
      else $error("sample pulse too long");
   chk_take_converts: assert property (
      sample_take |-> ##[0:1] (converting && !power_down)) else $error("no conversion");
   chk_conv_length: assert property (
      $rose(converting) |-> ##[68:71] $fell(converting)) else $error("bad length");
   chk_pd_after_end: assert property ($fell(converting) |-> power_down)
      else $error("no power down");
   chk_pd_during: assert property (converting |-> !power_down)
      else $error("powered down in conversion");
   chk_low_during_conv: assert property (
      converting && $past(converting) && chain_mode |->
      serial_result_out_oe && !serial_result_out) else $error("output not low");
   chk_no_restart: assert property (
      converting && $past(converting) |-> !sample_take) else $error("restarted");
   chk_mode_hold: assert property (
      converting && $past(converting) |-> $stable(chain_mode) && $stable(busy_mode))
      else $error("mode changed");
   chk_busy_bit_low: assert property (
      busy_mode && chain_mode && $rose(power_down) |-> !serial_result_out)
      else $error("busy bit not low");
   chk_oe_at_start: assert property (
      $changed(serial_result_out_oe) |-> sample_take)
      else $error("drive enable changed outside a start");
endmodule

bind adc_chain adc_chain_sva u_sva (
   .mclk                 (mclk),
   .nrst                 (nrst),
   .serial_result_out    (serial_result_out),
   .serial_result_out_oe (serial_result_out_oe),
   .sample_take          (sample_take),
   .converting           (converting),
   .power_down           (power_down),
   .chain_mode           (chain_mode),
   .busy_mode            (busy_mode)
);

// ==== tb/test_adc_chain.sv ====
// Bench of the daisy-chain readout: three readouts and one non-chain conversion through a peer model.
// Assumes mclk 20 ns and a 15 ns shift clock run in readout and for three cycles during conversion.
`timescale 1ns/1ns
module test_adc_chain;
   logic        mclk, nrst, sclk, conversion_start, chain_data_in, ready;
   logic [15:0] sample_code, word;
   logic [1:0]  wiring;
   logic        out, oe, take, conv, pd, cmode, bmode;
   int          miscompares, total_checks;

   adc_chain DUT (.mclk(mclk), .nrst(nrst), .sclk(sclk),
      .conversion_start(conversion_start), .chain_data_in(chain_data_in),
      .sample_code(sample_code), .serial_result_out(out), .serial_result_out_oe(oe),
      .sample_take(take), .converting(conv), .power_down(pd), .chain_mode(cmode),
      .busy_mode(bmode));
   adc_chain_peer u_peer (.sclk(sclk), .conversion_start(conversion_start),
      .ready(ready), .wiring(wiring), .word(word), .chain_data_in(chain_data_in));

   initial begin
      mclk = 1'b0;
      forever #10 mclk = ~mclk;
   end

   task automatic check_bit(input string name, input logic exp, input logic got);
      total_checks++;
      if (got !== exp) begin
         miscompares++;
         $display("unexpected %s expected %b seen %b", name, exp, got);
      end
   endtask

   task automatic final_report();
      $display("checks %0d mismatches %0d", total_checks, miscompares);
      if (miscompares == 0 && total_checks > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask

   task automatic wait_mclk(input int n);
      repeat (n) @(posedge mclk);
      #2;
   endtask

   task automatic start_conv(input logic lvl, input logic [15:0] code, input logic [1:0] w);
      int i;
      sclk = lvl;
      sample_code = code;
      wiring = w;
      wait_mclk(2);
      conversion_start = 1'b1;
      for (i = 0; i < 20 && conv !== 1'b1; i++) wait_mclk(1);
      if (conv !== 1'b1) begin
         miscompares++;
         final_report();
      end
      check_bit("converting", 1'b1, conv);
      check_bit("sample_take", 1'b1, take);
      check_bit("power_down", 1'b0, pd);
      repeat (3) begin
         #7 sclk = ~sclk;
         #8 sclk = ~sclk;
      end
      for (i = 0; i < 100 && pd !== 1'b1; i++) wait_mclk(1);
      if (pd !== 1'b1) begin
         miscompares++;
         final_report();
      end
      ready = 1'b1;
      wait_mclk(4);
   endtask

   // Start stays high until the last fall
   task automatic read_stream(input string name, input logic [47:0] exp, input int falls);
      int n;
      check_bit(name, exp[47], out);
      for (n = 1; n <= falls; n++) begin
         sclk = 1'b1;
         #8 sclk = 1'b0;
         #7 check_bit(name, exp[47-n], out);
      end
      conversion_start = 1'b0;
      ready = 1'b0;
      sclk = 1'b0;
      wait_mclk(3);
   endtask

   task automatic scen_plain();
      word = 16'hFFFF;
      start_conv(1'b0, 16'h8000, 2'h0);
      check_bit("chain_mode", 1'b1, cmode);
      check_bit("busy_mode", 1'b0, bmode);
      check_bit("oe", 1'b1, oe);
      read_stream("plain", {16'h8000, 16'hFFFF, 16'h0000}, 32);
   endtask

   task automatic scen_first();
      start_conv(1'b0, 16'h7FFF, 2'h1);
      read_stream("first", {16'h7FFF, 32'h0}, 17);
   endtask

   task automatic scen_busy();
      start_conv(1'b1, 16'hA5C3, 2'h2);
      check_bit("busy_mode", 1'b1, bmode);
      check_bit("chain_mode", 1'b1, cmode);
      read_stream("busy", {1'b0, 16'hA5C3, 31'h7FFFFFFF}, 18);
   endtask

   task automatic scen_cs();
      start_conv(1'b0, 16'h0000, 2'h3);
      check_bit("chain_mode", 1'b0, cmode);
      check_bit("oe", 1'b0, oe);
      check_bit("power_down", 1'b1, pd);
      conversion_start = 1'b0;
      ready = 1'b0;
      wait_mclk(3);
   endtask

   initial begin
      miscompares = 0;
      total_checks = 0;
      nrst = 1'b0;
      sclk = 1'b0;
      conversion_start = 1'b0;
      ready = 1'b0;
      wiring = 2'h0;
      word = 16'h0000;
      sample_code = 16'h0000;
      wait_mclk(5);
      nrst = 1'b1;
      wait_mclk(5);
      scen_plain();
      scen_first();
      scen_busy();
      scen_cs();
      final_report();
   end
endmodule
